// file: apsw_pin.sv
// dual-function strap / pump switch pin logic
`timescale 1ns/1ns
module apsw_pin (
    input  wire logic       core_clk,    // 10 MHz clock
    input  wire logic       nrst,        // async reset, active low
    input  wire logic       pin_i,       // pin level as seen at the pad
    input  wire logic [7:0] ctrl3_wdata, // control register 3 write data
    input  wire logic       ctrl3_we,    // control register 3 write strobe
    input  wire logic [6:0] addr_in,     // incoming address from bus slave
    input  wire logic       addr_valid,  // incoming address is valid
    output logic            pin_o,       // pin output level
    output logic            pin_oe,      // pin output enable, high = drive
    output logic [6:0]      slave_addr,  // own seven-bit address
    output logic            addr_match,  // registered address match
    output logic            psw_en,      // pump switch enable readback
    output logic            strap_lvl    // captured strap level
);
    // ****************************************
    // input synchroniser
    // ****************************************
    logic pin_sync;

    apsw_sync u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .d        (pin_i),
        .q        (pin_sync)
    );

    // ****************************************
    // strap capture sequence
    // ****************************************
    // the strap is taken once the synchroniser has flushed after release,
    // so the value never comes from the reset constant in the flops
    apsw_pkg::apsw_state_e state_q;
    apsw_pkg::apsw_state_e state_d;
    logic [2:0]            wait_q;
    logic [2:0]            wait_d;
    logic                  strap_d;
    logic                  run_d;

    always_comb begin
        state_d = state_q;
        wait_d  = wait_q;
        strap_d = strap_lvl;
        unique case (state_q)
            apsw_pkg::APSW_STATE_RESET: begin
                wait_d = {wait_q[1:0], 1'b0};
                if (wait_q[1]) begin
                    state_d = apsw_pkg::APSW_STATE_CAPTURE;
                end
            end
            apsw_pkg::APSW_STATE_CAPTURE: begin
                strap_d = pin_sync;
                state_d = apsw_pkg::APSW_STATE_RUN;
            end
            apsw_pkg::APSW_STATE_RUN: begin
                // stays here until the next reset, so the strap is never retaken
                state_d = apsw_pkg::APSW_STATE_RUN;
            end
        endcase
        run_d = (state_d == apsw_pkg::APSW_STATE_RUN);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q   <= apsw_pkg::APSW_STATE_RESET;
            wait_q    <= apsw_pkg::CAP_PENDING;
            strap_lvl <= apsw_pkg::STRAP_RESET;
        end else begin
            state_q   <= state_d;
            wait_q    <= wait_d;
            strap_lvl <= strap_d;
        end
    end

    // ****************************************
    // pump switch enable bit
    // ****************************************
    // writes that land before the strap is captured are dropped, so the
    // pin can never be turned around while the address is still being read
    logic en_d;

    always_comb begin
        en_d = psw_en;
        if ((state_q == apsw_pkg::APSW_STATE_RUN) && ctrl3_we) begin
            en_d = ctrl3_wdata[apsw_pkg::PSW_EN_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            psw_en <= apsw_pkg::ENABLE_RESET;
        end else begin
            psw_en <= en_d;
        end
    end

    // ****************************************
    // pin driver
    // ****************************************
    // driver only after capture, else released to the strap resistor;
    // the level idles low while released so a later enable starts clean
    apsw_pkg::apsw_pin_s pin_d;

    always_comb begin
        pin_d.oe = run_d && en_d;
        pin_d.o  = pin_d.oe & ~strap_d;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_o  <= pin_d.o;
            pin_oe <= pin_d.oe;
        end
    end

    // ****************************************
    // own address and compare
    // ****************************************
    logic [6:0] addr_d;
    logic       match_d;

    always_comb begin
        addr_d  = {apsw_pkg::ADDR_BASE[6:1], strap_d};
        match_d = addr_valid && (addr_in == slave_addr);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            slave_addr <= apsw_pkg::ADDR_BASE;
            addr_match <= 1'b0;
        end else begin
            slave_addr <= addr_d;
            addr_match <= match_d;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    a_oe_needs_en : assert property (@(posedge core_clk) disable iff (!nrst)
        pin_oe |-> psw_en)
        else $error("pin driven while enable clear");

    a_oe_follows_en : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == apsw_pkg::APSW_STATE_RUN) |-> (pin_oe == psw_en))
        else $error("pin drive does not follow enable");

    a_out_inverse : assert property (@(posedge core_clk) disable iff (!nrst)
        pin_oe |-> (pin_o == !strap_lvl))
        else $error("pin level not inverse");

    a_addr_value : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == apsw_pkg::APSW_STATE_RUN) |-> (slave_addr == (strap_lvl ? 7'h2d : 7'h2c)))
        else $error("bad address");

    a_addr_hold : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == apsw_pkg::APSW_STATE_RUN) ##1 (state_q == apsw_pkg::APSW_STATE_RUN)
        |-> $stable(slave_addr)) else $error("address changed after capture");

    a_addr_lsb : assert property (@(posedge core_clk) disable iff (!nrst)
        slave_addr[0] == strap_lvl)
        else $error("address lsb wrong");

    a_strap_hold : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == apsw_pkg::APSW_STATE_RUN) ##1 (state_q == apsw_pkg::APSW_STATE_RUN)
        |-> $stable(strap_lvl)) else $error("strap changed after capture");

    a_strap_capture : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == apsw_pkg::APSW_STATE_CAPTURE) |=> (strap_lvl == $past(pin_sync)))
        else $error("strap not taken from pin");

    a_capture_delay : assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(nrst) |-> (state_q == apsw_pkg::APSW_STATE_RESET) ##1
        (state_q == apsw_pkg::APSW_STATE_RESET) ##1 (state_q == apsw_pkg::APSW_STATE_CAPTURE))
        else $error("capture not on third edge");

    a_run_stays : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == apsw_pkg::APSW_STATE_RUN) |=> (state_q == apsw_pkg::APSW_STATE_RUN))
        else $error("left run before reset");

    a_no_early_oe : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q != apsw_pkg::APSW_STATE_RUN) |-> !pin_oe)
        else $error("early drive");

    a_en_reset : assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(nrst) |-> !psw_en)
        else $error("enable not reset");

    a_en_idle : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q != apsw_pkg::APSW_STATE_RUN) |-> !psw_en)
        else $error("enable set before capture");

    a_en_write : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == apsw_pkg::APSW_STATE_RUN && ctrl3_we) |=>
        (psw_en == $past(ctrl3_wdata[apsw_pkg::PSW_EN_BIT])))
        else $error("enable write lost");

    a_en_hold : assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == apsw_pkg::APSW_STATE_RUN && !ctrl3_we) |=> $stable(psw_en))
        else $error("enable changed without write");

    a_match : assert property (@(posedge core_clk) disable iff (!nrst)
        (addr_valid && addr_in == slave_addr) |=> addr_match)
        else $error("no match");

    a_match_other : assert property (@(posedge core_clk) disable iff (!nrst)
        (addr_valid && addr_in != slave_addr) |=> !addr_match)
        else $error("match on foreign address");

    a_match_clear : assert property (@(posedge core_clk) disable iff (!nrst)
        !addr_valid |=> !addr_match)
        else $error("match without valid address");

    // ****************************************
    // cover points
    // ****************************************
    c_drive_low   : cover property (@(posedge core_clk) disable iff (!nrst) pin_oe && !pin_o);
    c_drive_high  : cover property (@(posedge core_clk) disable iff (!nrst) pin_oe && pin_o);
    c_match_hi    : cover property (@(posedge core_clk) disable iff (!nrst)
        addr_match && strap_lvl);
    c_match_lo    : cover property (@(posedge core_clk) disable iff (!nrst)
        addr_match && !strap_lvl);
    c_early_write : cover property (@(posedge core_clk) disable iff (!nrst)
        (state_q != apsw_pkg::APSW_STATE_RUN) && ctrl3_we);
endmodule : apsw_pin

// file: apsw_pkg.sv
// package for the address strap / pump switch pin block
package apsw_pkg;

    // ****************************************
    // address and control layout
    // ****************************************
    localparam logic [6:0] ADDR_BASE     = 7'h2c;
    localparam int         PSW_EN_BIT    = 6;
    localparam logic [7:0] CTRL3_RESET   = 8'h00;
    localparam logic       ENABLE_RESET  = 1'b0;
    localparam logic       STRAP_RESET   = 1'b0;
    localparam logic [2:0] CAP_PENDING   = 3'b001;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        APSW_STATE_RESET   = 3'b001,
        APSW_STATE_CAPTURE = 3'b010,
        APSW_STATE_RUN     = 3'b100
    } apsw_state_e;

    typedef struct packed {
        logic o;
        logic oe;
    } apsw_pin_s;

endpackage : apsw_pkg

// file: apsw_sync.sv
// two-flop synchroniser for the strap pin level
`timescale 1ns/1ns
module apsw_sync (
    input  wire logic core_clk, // system clock
    input  wire logic nrst,     // async reset, active low
    input  wire logic d,        // asynchronous input
    output logic      q         // synchronised level
);
    logic meta_q;
    logic meta_d;
    logic q_d;

    always_comb begin
        meta_d = d;
        q_d    = meta_q;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end
endmodule : apsw_sync

// file: apsw_pump_model.sv
// strap resistor and external pump enable model at the pin's far side
`timescale 1ns/1ns
module apsw_pump_model (
    input  wire logic pin_o,   // level driven by the block
    input  wire logic pin_oe,  // block drives the pad
    input  wire logic strap,   // strap resistor direction
    output logic      pad,     // resolved pad level
    output logic      pump_on  // pump control away from strap level
);
    // released pad falls back to the strap, never holds the old level
    assign pad     = pin_oe ? pin_o : strap;
    assign pump_on = pin_oe && (pin_o != strap);
endmodule : apsw_pump_model

// file: tb_top.sv
// self-checking bench for the strap / pump switch pin
`timescale 1ns/1ns
module tb_top;
    logic       core_clk, nrst, strap, ctrl3_we, addr_valid, pad, pump_on;
    logic       pin_o, pin_oe, addr_match, psw_en, strap_lvl;
    logic [7:0] ctrl3_wdata;
    logic [6:0] addr_in, slave_addr;
    int         err_count, tests_run;
    apsw_pin u_apsw_pin (.core_clk(core_clk), .nrst(nrst), .pin_i(pad),
        .ctrl3_wdata(ctrl3_wdata), .ctrl3_we(ctrl3_we), .addr_in(addr_in),
        .addr_valid(addr_valid), .pin_o(pin_o), .pin_oe(pin_oe), .slave_addr(slave_addr),
        .addr_match(addr_match), .psw_en(psw_en), .strap_lvl(strap_lvl));
    apsw_pump_model u_apsw_pump_model (.pin_o(pin_o), .pin_oe(pin_oe), .strap(strap),
        .pad(pad), .pump_on(pump_on));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string name, input logic [6:0] exp, input logic [6:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic chk_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask : step
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // ****************************************
    // scenarios
    // ****************************************
    task automatic reset_capture(input logic lvl);
        strap = lvl;
        nrst = 1'b0;
        step;
        step;
        chk_bit("psw_en in reset", 1'b0, psw_en);
        chk_bit("pin_oe in reset", 1'b0, pin_oe);
        nrst = 1'b1;
        // writes inside the three capture cycles must all be dropped
        ctrl3_we = 1'b1;
        ctrl3_wdata = 8'h40;
        step;
        step;
        step;
        ctrl3_we = 1'b0;
        chk_bit("strap_lvl", lvl, strap_lvl);
        chk("slave_addr", lvl ? 7'h2d : 7'h2c, slave_addr);
        chk_bit("early write enable", 1'b0, psw_en);
        chk_bit("early write drive", 1'b0, pin_oe);
        chk_bit("pad released", lvl, pad);
    endtask : reset_capture
    task automatic addr_check(input logic lvl);
        addr_valid = 1'b1;
        addr_in = {apsw_pkg::ADDR_BASE[6:1], lvl};
        step;
        chk_bit("own match", 1'b1, addr_match);
        addr_in = {apsw_pkg::ADDR_BASE[6:1], ~lvl};
        step;
        chk_bit("other addr", 1'b0, addr_match);
        addr_valid = 1'b0;
    endtask : addr_check
    task automatic pump_cycle(input logic lvl);
        ctrl3_we = 1'b1;
        ctrl3_wdata = 8'h40;
        step;
        chk_bit("psw_en set", 1'b1, psw_en);
        chk_bit("pin_oe set", 1'b1, pin_oe);
        chk_bit("pad driven", ~lvl, pad);
        chk_bit("pump on", 1'b1, pump_on);
        ctrl3_wdata = 8'hbf; // back to back, only the enable bit cleared
        step;
        chk_bit("psw_en clear", 1'b0, psw_en);
        chk_bit("pin_oe clear", 1'b0, pin_oe);
        chk_bit("pad strap", lvl, pad);
        chk_bit("pump off", 1'b0, pump_on);
        ctrl3_wdata = 8'h40;
        step;
        ctrl3_we = 1'b0;
        chk_bit("pin_oe again", 1'b1, pin_oe);
    endtask : pump_cycle
    initial begin
        {nrst, strap, ctrl3_we, addr_valid, ctrl3_wdata, addr_in} = '0;
        err_count = 0;
        tests_run = 0;
        // reset while driving, with the other strap, re-captures the address
        reset_capture(1'b1);
        addr_check(1'b1);
        pump_cycle(1'b1);
        reset_capture(1'b0);
        addr_check(1'b0);
        pump_cycle(1'b0);
        reset_capture(1'b1);
        test_done();
    end
    initial begin
        #1000000;
        err_count++;
        test_done();
    end
endmodule : tb_top
